// *** logic/hcd_decoder.sv ***
// hub configuration image decoder top
`timescale 1ns/1ps
`include "hcd_cfg.svh"
module hcd_decoder import hcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic hs_connected,
  input wire logic self_powered,
  input wire logic desc_req_valid,
  input wire logic [7:0] desc_req_type,
  output logic desc_req_accept,
  output logic desc_req_stall,
  input wire logic [3:0] port_ind_req,
  output logic [3:0] port_ind_out,
  output logic load_done,
  output logic connect_enable,
  output logic vendor_class_mode,
  output logic hs_allowed,
  output hcd_fmt_t image_format,
  output hcd_ident_t ident,
  output hcd_hub_cfg_t hub_cfg
);
  logic byte_valid;
  logic [7:0] byte_data;
  logic [7:0] addr_r;
  logic busy_r;
  logic [7:0] sig_r, ocf_r, ports_r, maxp_fs_r, maxp_hs_r;
  logic [7:0] cc_fsb_r, cc_hsb_r, cc_fss_r, cc_hss_r, pgd_r, flags_r, nlang_r, smap_r;
  logic [3:0] active_r, remov_r;
  logic [15:0] vid_r, pid_r;
  logic [7:0] did_r;
  logic is_d4, is_d2, last;
  logic [2:0] cnt;
  logic [7:0] maxp_sel, cc_sel;
  logic [3:0] log_det;

  assign is_d4 = (sig_r == `HCD_SIG_D4);
  assign is_d2 = (sig_r == `HCD_SIG_D2);
  // compact stops after byte 12, d0 after byte 6, unknown after byte 1
  assign last = (addr_r == `HCD_LAST_ADDR) || (is_d2 && addr_r == `HCD_C_FLAGS)
    || (sig_r == `HCD_SIG_D0 && addr_r == `HCD_DID_HI)
    || (addr_r != `HCD_SIG_ADDR && !is_d4 && !is_d2 && sig_r != `HCD_SIG_D0);

  hcd_spi_reader u_rd (
    .clk(clk),
    .reset(reset),
    .start(busy_r),
    .stop(byte_valid && last),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b1;
      addr_r <= 8'h00;
      load_done <= 1'b0;
    end else if (busy_r && byte_valid) begin
      addr_r <= addr_r + 8'd1;
      if (last) begin
        busy_r <= 1'b0;
        load_done <= 1'b1;
      end
    end
  end

  // every field reloads its default at reset; bytes absent from a format never overwrite it, except byte 1 of an unknown image, which loads vid_r[7:0]
  always_ff @(posedge clk) begin
    if (reset) begin
      sig_r <= `HCD_BLANK;
      vid_r <= 16'h0000;
      pid_r <= 16'h0000;
      did_r <= 8'h00;
      ocf_r <= `HCD_DEF_OCF;
      ports_r <= `HCD_DEF_PORTS;
      maxp_fs_r <= `HCD_DEF_MAXP_FS;
      maxp_hs_r <= `HCD_DEF_MAXP_HS;
      cc_fsb_r <= `HCD_DEF_CC_FS;
      cc_hsb_r <= `HCD_DEF_CC_HS;
      cc_fss_r <= `HCD_DEF_CC_FS;
      cc_hss_r <= `HCD_DEF_CC_HSS;
      pgd_r <= `HCD_DEF_PGD;
      flags_r <= `HCD_DEF_FLAGS;
      nlang_r <= 8'h00;
      smap_r <= 8'h00;
    end else if (busy_r && byte_valid) begin
      if (addr_r == `HCD_SIG_ADDR) sig_r <= byte_data;
      else if (addr_r == `HCD_VID_LO) vid_r[7:0] <= byte_data;
      else if (addr_r == `HCD_VID_HI) vid_r[15:8] <= byte_data;
      else if (addr_r == `HCD_PID_LO) pid_r[7:0] <= byte_data;
      else if (addr_r == `HCD_PID_HI) pid_r[15:8] <= byte_data;
      else if (addr_r == `HCD_DID_HI) did_r <= byte_data;
      else if (is_d2) begin
        if (addr_r == `HCD_OCF) ocf_r <= byte_data;
        if (addr_r == `HCD_C_PORTS) ports_r <= byte_data;
        if (addr_r == `HCD_C_MAXP) begin
          maxp_fs_r <= byte_data;
          maxp_hs_r <= byte_data;
        end
        if (addr_r == `HCD_C_CTRL) begin
          cc_fsb_r <= byte_data;
          cc_hsb_r <= byte_data;
          cc_fss_r <= byte_data;
          cc_hss_r <= byte_data;
        end
        if (addr_r == `HCD_C_PGD) pgd_r <= byte_data;
        if (addr_r == `HCD_C_FLAGS) flags_r <= byte_data;
      end else if (is_d4) begin
        if (addr_r == `HCD_OCF) ocf_r <= byte_data;
        if (addr_r == `HCD_E_MAXP_FS) maxp_fs_r <= byte_data;
        if (addr_r == `HCD_E_MAXP_HS) maxp_hs_r <= byte_data;
        if (addr_r == `HCD_E_CC_FSB) cc_fsb_r <= byte_data;
        if (addr_r == `HCD_E_CC_HSB) cc_hsb_r <= byte_data;
        if (addr_r == `HCD_E_CC_FSS) cc_fss_r <= byte_data;
        if (addr_r == `HCD_E_CC_HSS) cc_hss_r <= byte_data;
        if (addr_r == `HCD_E_PGD) pgd_r <= byte_data;
        if (addr_r == `HCD_E_FLAGS) flags_r <= byte_data;
        if (addr_r == `HCD_E_NLANG) nlang_r <= byte_data;
        if (addr_r == `HCD_E_STRMAP) smap_r <= byte_data;
        if (addr_r == `HCD_E_ACTIVE) ports_r[7:4] <= byte_data[3:0];
        if (addr_r == `HCD_E_REMOV) ports_r[3:0] <= byte_data[3:0];
      end
    end
  end

  assign active_r = ports_r[7:4];
  assign remov_r = ports_r[3:0];

  // logical port k takes detachable bit k; bits at and above port_count stay clear
  always_comb begin
    cnt = 3'd0;
    log_det = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (active_r[i]) begin
        log_det[cnt[1:0]] = remov_r[cnt[1:0]];
        cnt = cnt + 3'd1;
      end
    end
  end

  assign maxp_sel = hs_allowed && hs_connected ? maxp_hs_r : maxp_fs_r;
  always_comb begin
    unique case ({self_powered, hs_allowed && hs_connected})
      2'b00: cc_sel = cc_fsb_r;
      2'b01: cc_sel = cc_hsb_r;
      2'b10: cc_sel = cc_fss_r;
      default: cc_sel = cc_hss_r;
    endcase
  end

  assign vendor_class_mode = load_done && (sig_r == `HCD_BLANK);
  assign connect_enable = load_done;
  assign hs_allowed = !flags_r[`HCD_BIT_FSO];
  always_comb begin
    unique case (sig_r)
      `HCD_SIG_D0: image_format = HCD_FMT_D0;
      `HCD_SIG_D2: image_format = HCD_FMT_D2;
      `HCD_SIG_D4: image_format = HCD_FMT_D4;
      default: image_format = HCD_FMT_NONE;
    endcase
  end
  assign ident.vendor_code = vid_r;
  assign ident.product_code = pid_r;
  assign ident.release_code = did_r;
  assign hub_cfg.live_port_fault_filter = ocf_r[7:4];
  assign hub_cfg.idle_port_fault_filter = ocf_r[3:0];
  assign hub_cfg.port_usable_mask = active_r;
  assign hub_cfg.port_detachable_mask = log_det;
  assign hub_cfg.port_count = cnt;
  assign hub_cfg.upstream_current_demand = maxp_sel;
  assign hub_cfg.controller_current_draw = cc_sel;
  assign hub_cfg.power_good_delay = pgd_r;
  assign hub_cfg.accept_zero_descriptor_type = flags_r[`HCD_BIT_AZD];
  assign hub_cfg.compound_flag = flags_r[`HCD_BIT_CMP];
  assign hub_cfg.fs_restrict_flag = flags_r[`HCD_BIT_FSO];
  assign hub_cfg.indicators_off_flag = flags_r[`HCD_BIT_NOIND];
  assign hub_cfg.shared_power_switch_flag = flags_r[`HCD_BIT_GANG];
  // b7 indicators, b2 compound; b4:b3 and b1:b0 read 01 per port, 00 when shared (10 would mean no protection)
  assign hub_cfg.hub_characteristics = {8'h00, !flags_r[`HCD_BIT_NOIND], 2'b00,
    1'b0, !flags_r[`HCD_BIT_GANG], flags_r[`HCD_BIT_CMP],
    1'b0, !flags_r[`HCD_BIT_GANG]};
  assign hub_cfg.language_count = nlang_r;
  assign hub_cfg.string_presence_map = smap_r;
  assign hub_cfg.string_ptr_base = `HCD_E_LANG + {nlang_r[6:0], 1'b0};
  assign port_ind_out = flags_r[`HCD_BIT_NOIND] ? 4'h0 : port_ind_req;

  always_comb begin
    desc_req_accept = 1'b0;
    desc_req_stall = 1'b0;
    if (desc_req_valid) begin
      if (desc_req_type == `HCD_DT_HUB) desc_req_accept = 1'b1;
      else if (desc_req_type == `HCD_DT_ZERO && flags_r[`HCD_BIT_AZD]) desc_req_accept = 1'b1;
      else desc_req_stall = 1'b1;
    end
  end
endmodule

// *** logic/hcd_cfg.svh ***
// constants of the hub configuration image decoder
`ifndef HCD_CFG_SVH
`define HCD_CFG_SVH
`define HCD_SIG_D0 8'hD0
`define HCD_SIG_D2 8'hD2
`define HCD_SIG_D4 8'hD4
`define HCD_BLANK 8'hFF
`define HCD_SIG_ADDR 8'h00
`define HCD_VID_LO 8'h01
`define HCD_VID_HI 8'h02
`define HCD_PID_LO 8'h03
`define HCD_PID_HI 8'h04
`define HCD_DID_HI 8'h06
`define HCD_OCF 8'h07
`define HCD_C_PORTS 8'h08
`define HCD_C_MAXP 8'h09
`define HCD_C_CTRL 8'h0A
`define HCD_C_PGD 8'h0B
`define HCD_C_FLAGS 8'h0C
`define HCD_E_MAXP_FS 8'h08
`define HCD_E_MAXP_HS 8'h09
`define HCD_E_CC_FSB 8'h0C
`define HCD_E_CC_HSB 8'h0D
`define HCD_E_CC_FSS 8'h0E
`define HCD_E_CC_HSS 8'h0F
`define HCD_E_PGD 8'h10
`define HCD_E_FLAGS 8'h11
`define HCD_E_FLAGS2 8'h12
`define HCD_E_NLANG 8'h14
`define HCD_E_STRMAP 8'h15
`define HCD_E_ACTIVE 8'h16
`define HCD_E_REMOV 8'h17
`define HCD_E_LANG 8'h18
`define HCD_LAST_ADDR 8'h18
`define HCD_DEF_OCF 8'h88
`define HCD_DEF_PORTS 8'hFF
`define HCD_DEF_MAXP_FS 8'h28
`define HCD_DEF_MAXP_HS 8'h57
`define HCD_DEF_CC_FS 8'h50
`define HCD_DEF_CC_HS 8'hAE
`define HCD_DEF_CC_HSS 8'h64
`define HCD_DEF_PGD 8'h32
`define HCD_DEF_FLAGS 8'h80
`define HCD_DEF_E_PORTS 8'h0F
`define HCD_DT_HUB 8'h29
`define HCD_DT_ZERO 8'h00
`define HCD_BIT_AZD 7
`define HCD_BIT_CMP 6
`define HCD_BIT_FSO 5
`define HCD_BIT_NOIND 4
`define HCD_BIT_GANG 2
`define HCD_BIT_SELFP 5
`define HCD_SCK_DIV 8'd16
`define HCD_CMD_READ 8'h03
`endif

// *** logic/hcd_pkg.sv ***
// types of the hub configuration image decoder
package hcd_pkg;
  typedef struct packed {
    logic [15:0] vendor_code;
    logic [15:0] product_code;
    logic [7:0] release_code;
  } hcd_ident_t;
  typedef struct packed {
    logic [3:0] live_port_fault_filter;
    logic [3:0] idle_port_fault_filter;
    logic [3:0] port_usable_mask;
    logic [3:0] port_detachable_mask;
    logic [2:0] port_count;
    logic [7:0] upstream_current_demand;
    logic [7:0] controller_current_draw;
    logic [7:0] power_good_delay;
    logic [15:0] hub_characteristics;
    logic accept_zero_descriptor_type;
    logic compound_flag;
    logic fs_restrict_flag;
    logic indicators_off_flag;
    logic shared_power_switch_flag;
    logic [7:0] language_count;
    logic [7:0] string_presence_map;
    logic [7:0] string_ptr_base;
  } hcd_hub_cfg_t;
  typedef enum logic [1:0] {HCD_FMT_NONE, HCD_FMT_D0, HCD_FMT_D2, HCD_FMT_D4} hcd_fmt_t;
endpackage

// *** logic/hcd_spi_reader.sv ***
// spi eeprom byte reader: read command then streams bytes from address zero
`timescale 1ns/1ps
`include "hcd_cfg.svh"
module hcd_spi_reader (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic stop,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] div_r;
  logic tick;
  logic miso_s1_r, miso_s2_r;
  logic [5:0] bitc_r;
  logic [23:0] cmd_r;
  logic [7:0] sh_r;
  logic act_r;
  assign tick = (div_r == `HCD_SCK_DIV - 8'd1);
  always_ff @(posedge clk) begin
    miso_s1_r <= spi_miso;
    miso_s2_r <= miso_s1_r;
  end
  always_ff @(posedge clk) begin
    if (reset || !act_r || tick) div_r <= 8'd0;
    else div_r <= div_r + 8'd1;
  end
  // sck high in second half of each bit period; sample on rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      act_r <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_sck <= 1'b0;
      spi_mosi <= 1'b0;
      bitc_r <= 6'd0;
      cmd_r <= 24'h0;
      sh_r <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (start && !act_r) begin
        act_r <= 1'b1;
        spi_cs_n <= 1'b0;
        cmd_r <= {`HCD_CMD_READ, 16'h0000};
        spi_mosi <= 1'(`HCD_CMD_READ >> 7);
        bitc_r <= 6'd0;
      end else if (act_r && stop) begin
        act_r <= 1'b0;
        spi_cs_n <= 1'b1;
        spi_sck <= 1'b0;
      end else if (act_r && div_r == (`HCD_SCK_DIV >> 1) - 8'd1) begin
        spi_sck <= 1'b1;
        if (bitc_r >= 6'd24) sh_r <= {sh_r[6:0], miso_s2_r};
      end else if (act_r && tick) begin
        spi_sck <= 1'b0;
        if (bitc_r < 6'd24) begin
          cmd_r <= {cmd_r[22:0], 1'b0};
          spi_mosi <= cmd_r[22];
          bitc_r <= bitc_r + 6'd1;
        end else begin
          spi_mosi <= 1'b0;
          if (bitc_r == 6'd31) begin
            bitc_r <= 6'd24;
            byte_valid <= 1'b1;
            byte_data <= sh_r;
          end else bitc_r <= bitc_r + 6'd1;
        end
      end
    end
  end
endmodule

// *** verification/hcd_decoder_properties.sv ***
// concurrent checks on the hub configuration image decoder ports
`timescale 1ns/1ps
module hcd_decoder_properties import hcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_cs_n,
  input wire logic desc_req_valid,
  input wire logic [7:0] desc_req_type,
  input wire logic desc_req_accept,
  input wire logic desc_req_stall,
  input wire logic [3:0] port_ind_out,
  input wire logic load_done,
  input wire logic connect_enable,
  input wire logic hs_allowed,
  input wire hcd_hub_cfg_t hub_cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire [15:0] hc = hub_cfg.hub_characteristics;
  wire g = hub_cfg.shared_power_switch_flag;
  zero_type_a: assert property (desc_req_valid && desc_req_type == 8'h00 |->
    desc_req_accept == hub_cfg.accept_zero_descriptor_type && desc_req_stall != desc_req_accept)
    else $error("zero type answered wrongly");
  hub_type_a: assert property (desc_req_valid && desc_req_type == 8'h29 |->
    desc_req_accept && !desc_req_stall)
    else $error("hub type not accepted");
  compound_bit_a: assert property (load_done |-> hc[2] == hub_cfg.compound_flag)
    else $error("compound bit wrong");
  fs_only_a: assert property (hub_cfg.fs_restrict_flag |-> !hs_allowed)
    else $error("high speed allowed");
  ind_off_a: assert property (hub_cfg.indicators_off_flag |-> port_ind_out == 4'h0 && !hc[7])
    else $error("indicators not blanked");
  power_switch_a: assert property (load_done |-> {hc[4:3], hc[1:0]} == {1'b0, !g, 1'b0, !g})
    else $error("switching bits wrong");
  port_count_a: assert property (load_done |->
    hub_cfg.port_count == $countones(hub_cfg.port_usable_mask))
    else $error("port count wrong");
  done_hold_a: assert property (load_done |=> load_done && connect_enable && spi_cs_n)
    else $error("load state not held");
  read_start_a: assert property ($fell(reset) |-> ##[0:2] !spi_cs_n)
    else $error("read not started");
  ptr_base_a: assert property (load_done |->
    hub_cfg.string_ptr_base == 8'd24 + {hub_cfg.language_count[6:0], 1'b0})
    else $error("string pointer base wrong");
  cover property (desc_req_valid && desc_req_type == 8'h00 && desc_req_accept);
  cover property (desc_req_valid && desc_req_stall);
  cover property ($rose(load_done));
endmodule

bind hcd_decoder hcd_decoder_properties i_props (.clk(clk), .reset(reset), .spi_cs_n(spi_cs_n),
  .desc_req_valid(desc_req_valid), .desc_req_type(desc_req_type), .desc_req_accept(desc_req_accept),
  .desc_req_stall(desc_req_stall), .port_ind_out(port_ind_out), .load_done(load_done),
  .connect_enable(connect_enable), .hs_allowed(hs_allowed), .hub_cfg(hub_cfg));

// *** verification/hcd_eeprom_model.sv ***
// spi eeprom model serving a byte image, byte zero in the top bits
`timescale 1ns/1ps
module hcd_eeprom_model (
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic [255:0] image
);
  int n = 0;
  int a;
  logic [23:0] cmd;
  initial spi_miso = 1'b0;
  always @(negedge spi_cs_n) n = 0;
  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      if (n < 24) cmd = {cmd[22:0], spi_mosi};
      n = n + 1;
    end
  end
  // change on the falling clock so the bit is settled at the next rise
  always @(negedge spi_sck) begin
    a = int'(cmd[15:0]) * 8 + n - 24;
    if (!spi_cs_n && n >= 24) spi_miso = (cmd[23:16] == 8'h03 && a < 256) ? image[255 - a] : ~spi_miso;
  end
  // no pull resistor on the line: show the inverse, never a stale bit
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;
endmodule

// *** verification/testbench.sv ***
// self-checking bench of the hub configuration image decoder
`timescale 1ns/1ps
module testbench import hcd_pkg::*; ;
  logic clk, cs_n, sck, mosi, miso, acc, stl, done, conn, vcm, hsa;
  logic reset = 1'b1;
  logic hs = 1'b1;
  logic selfp = 1'b0;
  logic dv = 1'b0;
  logic [7:0] dt = 8'h00;
  logic [3:0] ind_req = 4'hF;
  logic [3:0] ind;
  logic [255:0] img = {256{1'b1}};
  hcd_fmt_t fmt;
  hcd_ident_t id;
  hcd_hub_cfg_t cfg;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  hcd_decoder i_hcd_decoder (.clk(clk), .reset(reset), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .hs_connected(hs), .self_powered(selfp), .desc_req_valid(dv), .desc_req_type(dt),
    .desc_req_accept(acc), .desc_req_stall(stl), .port_ind_req(ind_req), .port_ind_out(ind),
    .load_done(done), .connect_enable(conn), .vendor_class_mode(vcm), .hs_allowed(hsa),
    .image_format(fmt), .ident(id), .hub_cfg(cfg));
  hcd_eeprom_model i_mem (.spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso), .image(img));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one load per reset: the reader only runs once after release
  task automatic load(input logic [255:0] im);
    int k;
    img = im;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 6000) begin
      @(negedge clk);
      k++;
    end
    chk({done, conn}, 2'b11);
  endtask

  task automatic desc(input logic [7:0] t, input logic a);
    dt = t;
    dv = 1'b1;
    #1;
    chk({acc, stl}, {a, !a});
    @(negedge clk);
    dv = 1'b0;
    // one idle cycle so a following call never re-raises valid in the same step
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    load({104'hD2341278_56EE9A3C_B641621574, {152{1'b1}}});
    chk({fmt, id}, {HCD_FMT_D2, 16'h1234, 16'h5678, 8'h9A});
    chk({cfg.live_port_fault_filter, cfg.idle_port_fault_filter}, 8'h3C);
    chk({cfg.port_usable_mask, cfg.port_detachable_mask, cfg.port_count}, {8'hB6, 3'd3});
    chk({cfg.upstream_current_demand, cfg.controller_current_draw, cfg.power_good_delay}, 24'h416215);
    chk({cfg.compound_flag, cfg.hub_characteristics[2], hsa, vcm}, 4'b1100);
    chk({ind, cfg.hub_characteristics[7]}, 5'h00);
    chk({cfg.hub_characteristics[4:3], cfg.hub_characteristics[1:0]}, 4'b0000);
    desc(8'h00, 1'b0);
    desc(8'h29, 1'b1);
    selfp = 1'b1;
    load({200'hD4341278_56009A5A_11220000_31323334_0A800000_03070504_09, {56{1'b1}}});
    chk(fmt, HCD_FMT_D4);
    chk({cfg.live_port_fault_filter, cfg.idle_port_fault_filter, cfg.power_good_delay}, 16'h5A0A);
    chk({cfg.upstream_current_demand, cfg.controller_current_draw}, 16'h2234);
    chk({cfg.port_usable_mask, cfg.port_detachable_mask, cfg.port_count}, {8'h50, 3'd2});
    chk({cfg.language_count, cfg.string_presence_map, cfg.string_ptr_base}, 24'h03071E);
    chk({hsa, ind, cfg.hub_characteristics[7], cfg.hub_characteristics[4:3], cfg.hub_characteristics[1:0]},
      10'b1_1111_1_0101);
    desc(8'h00, 1'b1);
    desc(8'h05, 1'b0);
    hs = 1'b0;
    #1;
    chk({cfg.upstream_current_demand, cfg.controller_current_draw}, 16'h1133);
    @(negedge clk);
    hs = 1'b1;
    selfp = 1'b0;
    // trailing bytes are non-default so a format that reads past byte 6 shows up
    load({96'hD0CDAB01EF00421230410203, {160{1'b1}}});
    chk(id, {16'hABCD, 16'hEF01, 8'h42});
    chk({cfg.live_port_fault_filter, cfg.idle_port_fault_filter, cfg.port_usable_mask,
      cfg.port_detachable_mask, cfg.port_count}, {16'h88FF, 3'd4});
    chk({cfg.upstream_current_demand, cfg.controller_current_draw, cfg.power_good_delay}, 24'h57AE32);
    chk({cfg.accept_zero_descriptor_type, cfg.fs_restrict_flag, hsa, fmt}, {3'b101, HCD_FMT_D0});
    load({256{1'b1}});
    chk({vcm, fmt}, {1'b1, HCD_FMT_NONE});
    print_verdict();
  end
endmodule
